// ### rtl/event_pin_time_stamp.sv
// Event pin time-stamp capture with eight-record history
`timescale 1ns/1ns
`default_nettype none
`include "stamp_consts.svh"

module event_pin_time_stamp #(
    parameter int TICK_CYCLES = `TICK256_PERIOD_NS / `CLK_PERIOD_NS
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic event_input_pin_i,
    input wire logic [9:0] subsec_i,
    input wire logic [55:0] date_time_i,
    input wire logic [7:0] status_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic int_oe_o,
    output logic int_out_o,
    output logic [1:0] pull_up_sel_o,
    output logic pull_down_sel_o
);
    // =======================================================
    // Registers
    stamp_pkg::byte_t ext_q, ext_d, ctl_q, ctl_d, setup_q, setup_d;
    stamp_pkg::byte_t ctrl1_q, ctrl1_d, src_q, src_d, rdata_d;
    logic trig_en_q, trig_en_d, evf_q, evf_d;
    logic [2:0] ptr_q, ptr_d;
    logic full_q, full_d, empty_q, empty_d, irq_q, irq_d, pd_q, pd_d;
    logic [1:0] pu_q, pu_d;
    stamp_pkg::record_t last_q, last_d, new_rec, hist_rec;
    stamp_pkg::record_t rec_q [8];
    stamp_pkg::debounce_t db_sel;
    logic stamp_en, ovw, clr_flag, bus_trig, pin_event, cap_w, blocked;
    logic [6:0] byte_off;
    logic [2:0] hist_idx;

    assign stamp_en = ext_q[`STAMP_ENABLE_BIT];
    assign ovw = setup_q[`OVERWRITE_BIT];
    assign db_sel = stamp_pkg::debounce_t'(
        setup_q[`DEBOUNCE_HI_BIT:`DEBOUNCE_LO_BIT]);
    assign clr_flag = reg_we_i && reg_addr_i == `FLAG_STAT_ADDR
        && !reg_wdata_i[`EVENT_FLAG_BIT];
    assign bus_trig = reg_re_i && reg_addr_i == `TRIG_PORT_ADDR
        && trig_en_q;
    assign blocked = full_q && !ovw;
    assign cap_w = (pin_event || bus_trig) && !blocked;
    assign hist_idx = reg_addr_i[5:3];
    assign byte_off = {1'b0, reg_addr_i[2:0], 3'b000} + 7'h08;

    // =======================================================
    // Pin synchroniser: a change counts when stages two and three agree
    logic sync1_q, sync2_q, sync3_q, pin_q, pin_d;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= event_input_pin_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // =======================================================
    // Filter tick divider: 256 Hz base, slower ticks by sub-count
    logic [19:0] div_q, div_d;
    logic [4:0] sub_q, sub_d;
    logic tick256, tick_sel;
    always_comb begin
        tick256 = div_q == 20'(TICK_CYCLES - 1);
        div_d = tick256 ? 20'h0_0000 : div_q + 20'h0_0001;
        sub_d = tick256 ? sub_q + 5'h01 : sub_q;
        case (db_sel)
            stamp_pkg::DB_256HZ: tick_sel = tick256;
            stamp_pkg::DB_64HZ: tick_sel = tick256 && sub_q[1:0] == 2'h3;
            stamp_pkg::DB_8HZ: tick_sel = tick256 && sub_q == 5'h1f;
            default: tick_sel = 1'b0;
        endcase
    end

    // =======================================================
    // Debounce and single-shot event detection
    logic active, armed_q, armed_d;
    logic [1:0] dbc_q, dbc_d;
    always_comb begin
        pin_d = (sync2_q == sync3_q) ? sync3_q : pin_q;
        active = pin_q == setup_q[`EVENT_POL_BIT];
        dbc_d = dbc_q;
        armed_d = armed_q;
        pin_event = 1'b0;
        if (!active) begin
            dbc_d = 2'h0;
            armed_d = 1'b1;
        end else if (db_sel == stamp_pkg::DB_NONE) begin
            pin_event = armed_q && stamp_en;
            armed_d = 1'b0;
        end else begin
            if (tick_sel && dbc_q != 2'(`DEBOUNCE_TICKS))
                dbc_d = dbc_q + 2'h1;
            // Two ticks seen means the level outlasted one full period
            if (dbc_q == 2'(`DEBOUNCE_TICKS) && armed_q) begin
                pin_event = stamp_en;
                armed_d = 1'b0;
            end
        end
    end

    // =======================================================
    // Record build with filter-dependent masking
    stamp_pkg::byte_t b20, b21;
    always_comb begin
        b20 = {6'h00, subsec_i[1:0]};
        b21 = subsec_i[9:2];
        case (db_sel)
            stamp_pkg::DB_256HZ: b20[0] = 1'b0;
            stamp_pkg::DB_64HZ: begin
                b20[1:0] = 2'h0;
                b21[0] = 1'b0;
            end
            stamp_pkg::DB_8HZ: begin
                b20[1:0] = 2'h0;
                b21[0] = 1'b0;
            end
            default: ;
        endcase
        new_rec = {status_i & `STATUS_MASK, date_time_i, b21, b20};
        hist_rec = new_rec;
        hist_rec[11:8] = db_sel == stamp_pkg::DB_8HZ ? 4'h0 : b21[3:0];
    end

    // =======================================================
    // Pointer, flag, interrupt and register next state
    always_comb begin
        ext_d = ext_q;
        ctl_d = ctl_q;
        setup_d = setup_q;
        ctrl1_d = ctrl1_q;
        src_d = src_q;
        trig_en_d = trig_en_q;
        ptr_d = ptr_q;
        full_d = full_q;
        empty_d = empty_q;
        last_d = last_q;
        evf_d = evf_q && !clr_flag;
        if (cap_w) begin
            last_d = new_rec;
            evf_d = 1'b1;
            empty_d = 1'b0;
            ptr_d = ptr_q + 3'h1;
            if (ptr_q == 3'h7) begin
                full_d = 1'b1;
                if (!ovw)
                    ptr_d = ptr_q;
            end
        end
        if (reg_we_i) begin
            if (reg_addr_i == `EXT_CTRL_ADDR)
                ext_d = reg_wdata_i;
            else if (reg_addr_i == `IRQ_CTRL_ADDR)
                ctl_d = reg_wdata_i;
            else if (reg_addr_i == `EVENT_INPUT_PIN_SETUP_ADDR)
                setup_d = reg_wdata_i & `SETUP_WMASK;
            else if (reg_addr_i == `TRIG_CTRL_ADDR)
                trig_en_d = reg_wdata_i[`TRIG_ENABLE_BIT];
            else if (reg_addr_i == `STAMP_CTRL1_ADDR)
                ctrl1_d = reg_wdata_i & `CTRL1_WMASK;
            else if (reg_addr_i == `STAMP_SRC_ADDR)
                src_d = reg_wdata_i & `SRC_WMASK;
        end
        irq_d = ctl_q[`EVENT_IRQ_EN_BIT] && evf_q;
        pu_d = 2'h0;
        pd_d = 1'b0;
        if (!setup_q[`PULL_DOWN_BIT])
            pu_d = setup_q[`PULL_UP_HI_BIT:`PULL_UP_LO_BIT];
        else if (setup_q[`PULL_UP_HI_BIT:`PULL_UP_LO_BIT] == 2'h0)
            pd_d = 1'b1;
        // Remaining codes fall through with no resistor
    end

    // =======================================================
    // Read data, registered one cycle after the strobe
    always_comb begin
        rdata_d = `REG_RESET;
        if (!reg_re_i)
            rdata_d = reg_rdata_o;
        else if (reg_addr_i == `EXT_CTRL_ADDR)
            rdata_d = ext_q;
        else if (reg_addr_i == `FLAG_STAT_ADDR)
            rdata_d = {5'h00, evf_q, 2'h0};
        else if (reg_addr_i == `IRQ_CTRL_ADDR)
            rdata_d = ctl_q;
        else if (reg_addr_i >= `STAMP_LAST_LO
            && reg_addr_i <= `STAMP_LAST_HI)
            rdata_d = last_q[{reg_addr_i[3:0], 3'b000} +: 8];
        else if (reg_addr_i == `EVENT_INPUT_PIN_SETUP_ADDR)
            rdata_d = setup_q;
        else if (reg_addr_i == `TRIG_CTRL_ADDR)
            rdata_d = {7'h00, trig_en_q};
        else if (reg_addr_i == `TRIG_PORT_ADDR)
            rdata_d = 8'h00;
        else if (reg_addr_i == `STAMP_CTRL1_ADDR)
            rdata_d = ctrl1_q;
        else if (reg_addr_i == `STAMP_SRC_ADDR)
            rdata_d = src_q;
        else if (reg_addr_i == `STAMP_PTR_ADDR)
            rdata_d = {3'h0, full_q, empty_q, ptr_q};
        else if (reg_addr_i >= `HIST_BASE && reg_addr_i <= `HIST_LAST)
            rdata_d = rec_q[hist_idx][byte_off +: 8];
    end

    // =======================================================
    // History storage, one write enable per entry
    for (genvar i = 0; i < 8; i++) begin : g_rec
        stamp_pkg::record_t rec_d;
        always_comb begin
            rec_d = (cap_w && ptr_q == 3'(i)) ? hist_rec : rec_q[i];
        end
        always_ff @(posedge mclk_i or negedge arst_n_i) begin
            if (!arst_n_i)
                rec_q[i] <= '0;
            else
                rec_q[i] <= rec_d;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_q <= 20'h0_0000;
            sub_q <= 5'h00;
            pin_q <= 1'b0;
            dbc_q <= 2'h0;
            armed_q <= 1'b0;
            ext_q <= `REG_RESET;
            ctl_q <= `REG_RESET;
            setup_q <= `REG_RESET;
            ctrl1_q <= `REG_RESET;
            src_q <= `REG_RESET;
            trig_en_q <= 1'b0;
            evf_q <= 1'b0;
            ptr_q <= 3'h0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
            last_q <= '0;
            irq_q <= 1'b0;
            pu_q <= 2'h0;
            pd_q <= 1'b0;
            reg_rdata_o <= `REG_RESET;
        end else begin
            div_q <= div_d;
            sub_q <= sub_d;
            pin_q <= pin_d;
            dbc_q <= dbc_d;
            armed_q <= armed_d;
            ext_q <= ext_d;
            ctl_q <= ctl_d;
            setup_q <= setup_d;
            ctrl1_q <= ctrl1_d;
            src_q <= src_d;
            trig_en_q <= trig_en_d;
            evf_q <= evf_d;
            ptr_q <= ptr_d;
            full_q <= full_d;
            empty_q <= empty_d;
            last_q <= last_d;
            irq_q <= irq_d;
            pu_q <= pu_d;
            pd_q <= pd_d;
            reg_rdata_o <= rdata_d;
        end
    end

    // Open-drain: level is always low, only the enable moves
    assign int_oe_o = irq_q;
    assign int_out_o = 1'b0;
    assign pull_up_sel_o = pu_q;
    assign pull_down_sel_o = pd_q;

    // =======================================================
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    ets_gate_a: assert property (pin_event |-> stamp_en)
        else $error("pin capture while stamping is off");
    flag_set_a: assert property (cap_w |=> evf_q)
        else $error("flag not set after capture");
    flag_hold_a: assert property (evf_q && !clr_flag |=> evf_q)
        else $error("flag dropped without clear");
    flag_clear_a: assert property (clr_flag && !cap_w |=> !evf_q)
        else $error("flag survived a zero write");
    irq_drive_a: assert property (##1 int_oe_o ==
        $past(ctl_q[2] && evf_q))
        else $error("interrupt enable mismatch");
    ptr_step_a: assert property (cap_w && ptr_q != 3'h7 |=>
        ptr_q == $past(ptr_q) + 3'h1)
        else $error("pointer did not advance");
    ptr_wrap_a: assert property (cap_w && ovw && ptr_q == 3'h7 |=>
        ptr_q == 3'h0 && full_q)
        else $error("pointer did not wrap");
    stop_full_a: assert property (full_q && !ovw |-> !cap_w)
        else $error("capture past the last record");
    coarse_mask_a: assert property (cap_w &&
        db_sel == stamp_pkg::DB_8HZ |=> !last_q[8] && last_q[1:0] == 2'h0)
        else $error("invalid sub-second bits kept");
    pull_bad_a: assert property (setup_q[4] && setup_q[3:2] != 2'h0
        |=> !pull_down_sel_o && pull_up_sel_o == 2'h0)
        else $error("reserved pull code drives a resistor");
    trig_data_a: assert property (bus_trig && !blocked |=>
        reg_rdata_o == 8'h00 && evf_q)
        else $error("trigger read not zero or no capture");
    pin_cap_c: cover property (pin_event ##1 evf_q);
    wrap_c: cover property (cap_w && ovw && ptr_q == 3'h7);
    filt_c: cover property (pin_event && db_sel == stamp_pkg::DB_64HZ);
    bus_c: cover property (bus_trig);
endmodule : event_pin_time_stamp
`default_nettype wire

// ### rtl/stamp_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef STAMP_CONSTS_SVH
`define STAMP_CONSTS_SVH
// ===========================================================
// Register offsets
`define EXT_CTRL_ADDR 8'h1d
`define FLAG_STAT_ADDR 8'h1e
`define IRQ_CTRL_ADDR 8'h1f
`define STAMP_LAST_LO 8'h20
`define STAMP_LAST_HI 8'h29
`define EVENT_INPUT_PIN_SETUP_ADDR 8'h2b
`define TRIG_CTRL_ADDR 8'h2e
`define TRIG_PORT_ADDR 8'h2f
`define STAMP_CTRL1_ADDR 8'h34
`define STAMP_SRC_ADDR 8'h35
`define STAMP_PTR_ADDR 8'h36
`define HIST_BASE 8'h40
`define HIST_LAST 8'h7f
// ===========================================================
// Field positions
`define STAMP_ENABLE_BIT 2
`define EVENT_FLAG_BIT 2
`define EVENT_IRQ_EN_BIT 2
`define EVENT_POL_BIT 7
`define DEBOUNCE_HI_BIT 6
`define DEBOUNCE_LO_BIT 5
`define PULL_DOWN_BIT 4
`define PULL_UP_HI_BIT 3
`define PULL_UP_LO_BIT 2
`define OVERWRITE_BIT 1
`define TRIG_ENABLE_BIT 0
`define FULL_BIT 4
`define EMPTY_BIT 3
// ===========================================================
// Writable masks, recorded status mask and reset values
`define SETUP_WMASK 8'hfe
`define CTRL1_WMASK 8'h07
`define SRC_WMASK 8'h0f
`define STATUS_MASK 8'h3a
`define REG_RESET 8'h00
// ===========================================================
// Timing: base filter tick is 256 Hz
`define CLK_PERIOD_NS 4
`define TICK256_PERIOD_NS 3906250
`define TICKS_PER_64HZ 4
`define TICKS_PER_8HZ 32
`define DEBOUNCE_TICKS 2
`endif

// ### rtl/stamp_pkg.sv
// Types shared by the event time-stamp block
package stamp_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [79:0] record_t;
    typedef enum logic [1:0] {
        DB_NONE = 2'b00,
        DB_256HZ = 2'b01,
        DB_64HZ = 2'b10,
        DB_8HZ = 2'b11
    } debounce_t;
endpackage : stamp_pkg

// ### tb/event_source.sv
// Far-side model of the event pin: driver plus the internal pull network
`timescale 1ns/1ns
`default_nettype none

module event_source (
    input wire logic mclk_i,
    input wire logic drive_en_i,
    input wire logic drive_lvl_i,
    input wire logic [1:0] pull_up_sel_i,
    input wire logic pull_down_sel_i,
    output logic pin_o
);
    logic last_q = 1'h0;

    always_ff @(posedge mclk_i) begin
        last_q <= pin_o;
    end

    // A floating pin shows the inverse of its last level, so a missing
    // pull is never hidden by the simulator's choice of value
    always_comb begin
        if (drive_en_i) begin
            pin_o = drive_lvl_i;
        end else if (pull_up_sel_i != 2'h0) begin
            pin_o = 1'h1;
        end else if (pull_down_sel_i) begin
            pin_o = 1'h0;
        end else begin
            pin_o = ~last_q;
        end
    end
endmodule : event_source

`default_nettype wire

// ### tb/event_pin_time_stamp_tb.sv
// Self-checking bench for the event pin time-stamp block
`timescale 1ns/1ns
`default_nettype none

module event_pin_time_stamp_tb;
    localparam int RUN_CYCLES = 20000;
    logic clk, pin, int_oe, pd;
    logic arst_n = 1'h0;
    logic drv_en = 1'h1;
    logic drv_lvl = 1'h0;
    logic we = 1'h0;
    logic re = 1'h0;
    logic [9:0] subsec = 10'h3a5;
    logic [55:0] dt = 56'h19_0312_0345_5607;
    logic [7:0] st = 8'hff;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, v;
    logic [1:0] pu;
    int err_total = 0;
    int comparisons = 0;
    // ===========================================================
    // Register rows: {address, write data, value read back}
    logic [23:0] rows [11] = '{24'h1d_fbfb, 24'h1f_ffff, 24'h2b_fffe,
        24'h2e_fe00, 24'h34_ff07, 24'h35_ff0f, 24'h1e_ff00, 24'h30_ff00,
        24'h2f_0000, 24'h36_ff08, 24'h20_ff00};
    // Valid-bit masks and hold lengths per filter setting
    logic [7:0] m20 [4] = '{8'h03, 8'h02, 8'h00, 8'h00};
    logic [7:0] m21 [4] = '{8'hff, 8'hff, 8'hfe, 8'hfe};
    logic [7:0] mh [4] = '{8'hff, 8'hff, 8'hfe, 8'hf0};
    int hold [4] = '{20, 20, 60, 300};

    event_pin_time_stamp #(.TICK_CYCLES(4)) dut (
        .mclk_i(clk),
        .arst_n_i(arst_n),
        .event_input_pin_i(pin),
        .subsec_i(subsec),
        .date_time_i(dt),
        .status_i(st),
        .reg_we_i(we),
        .reg_re_i(re),
        .reg_addr_i(addr),
        .reg_wdata_i(wdata),
        .reg_rdata_o(rdata),
        .int_oe_o(int_oe),
        .int_out_o(),
        .pull_up_sel_o(pu),
        .pull_down_sel_o(pd)
    );

    event_source src (
        .mclk_i(clk),
        .drive_en_i(drv_en),
        .drive_lvl_i(drv_lvl),
        .pull_up_sel_i(pu),
        .pull_down_sel_i(pd),
        .pin_o(pin)
    );

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    // ===========================================================
    // Bus and pin tasks: each starts and ends 1 ns after a rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        we = 1'h1;
        cyc(1);
        we = 1'h0;
        cyc(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr = a;
        re = 1'h1;
        cyc(1);
        re = 1'h0;
        d = rdata;
        cyc(1);
    endtask : rd

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g, input logic [7:0] m);
        comparisons++;
        if ((g & m) !== (e & m)) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e & m, g & m);
        end
    endtask : chk

    task automatic rc(input logic [7:0] a, input logic [7:0] e,
                      input logic [7:0] m);
        rd(a, v);
        chk($sformatf("reg %h", a), e, v, m);
    endtask : rc

    task automatic wait_oe(input logic e, input int n);
        int j;
        for (j = 0; j < n && int_oe !== e; j++) cyc(1);
        chk("irq", {7'h00, e}, {7'h00, int_oe}, 8'hff);
    endtask : wait_oe

    function automatic logic [7:0] sb(input int k);
        if (k == 0) return {6'h00, subsec[1:0]};
        if (k == 1) return subsec[9:2];
        if (k == 9) return st & 8'h3a;
        return dt[8*(k-2) +: 8];
    endfunction : sb

    task automatic chk_stamp(input logic [7:0] a0, input logic [7:0] a1);
        int k;
        for (k = 0; k < 10; k++) begin
            rd(8'h20 + k[7:0], v);
            chk("stamp", sb(k), v, k == 0 ? a0 : (k == 1 ? a1 : 8'hff));
        end
    endtask : chk_stamp

    task automatic do_reset();
        arst_n = 1'h0;
        cyc(12);
        arst_n = 1'h1;
        cyc(1);
    endtask : do_reset

    task automatic cfg(input logic [7:0] s);
        drv_lvl = ~s[7];
        wr(8'h2b, s);
        wr(8'h1f, 8'h04);
        wr(8'h1d, 8'h04);
        cyc(10);
    endtask : cfg

    task automatic pulse(input logic act, input int n);
        drv_lvl = act;
        cyc(n);
        drv_lvl = ~act;
        cyc(40);
    endtask : pulse

    task automatic end_test(input string nm);
        $display("test %s finished", nm);
    endtask : end_test

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // Guards against a hang; the full run needs well under a fifth of this
    initial begin
        repeat (RUN_CYCLES) @(posedge clk);
        err_total++;
        test_done();
    end

    // ===========================================================
    // Main sequence
    initial begin
        int i;
        do_reset();
        rc(8'h36, 8'h08, 8'hff);
        chk("irq", 8'h00, {7'h00, int_oe}, 8'hff);
        for (i = 0; i < 11; i++) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rc(rows[i][23:16], rows[i][7:0], 8'hff);
        end
        end_test("registers");
        do_reset();
        for (i = 0; i < 8; i++) begin
            wr(8'h2b, {3'h0, i[2:0], 2'h0});
            cyc(2);
            v = i > 4 ? 8'h00 : (i == 4 ? 8'h04 : {6'h00, i[1:0]});
            chk("pull", v, {5'h00, pd, pu}, 8'hff);
        end
        end_test("pull select");
        cfg(8'h80);
        drv_lvl = 1'h1;
        wait_oe(1'h1, 10);
        chk_stamp(8'hff, 8'hff);
        rc(8'h36, 8'h01, 8'hff);
        rc(8'h1e, 8'h04, 8'hff);
        rc(8'h40, subsec[9:2], 8'hff);
        rc(8'h41, dt[7:0], 8'hff);
        cyc(20);
        rc(8'h36, 8'h01, 8'hff);
        drv_lvl = 1'h0;
        wr(8'h1e, 8'h04);
        rc(8'h1e, 8'h04, 8'hff);
        wr(8'h1e, 8'h00);
        wait_oe(1'h0, 3);
        rc(8'h1e, 8'h00, 8'hff);
        end_test("pin event");
        wr(8'h1f, 8'h00);
        pulse(1'h1, 10);
        rc(8'h1e, 8'h04, 8'hff);
        wait_oe(1'h0, 1);
        wr(8'h1f, 8'h04);
        wait_oe(1'h1, 3);
        wr(8'h1f, 8'h00);
        wait_oe(1'h0, 3);
        wr(8'h1e, 8'h00);
        wr(8'h1d, 8'h00);
        pulse(1'h1, 10);
        rc(8'h36, 8'h02, 8'hff);
        drv_lvl = 1'h1;
        wr(8'h2b, 8'h00);
        cyc(10);
        wr(8'h1d, 8'h04);
        pulse(1'h0, 10);
        rc(8'h36, 8'h03, 8'hff);
        end_test("interrupt, enable, polarity");
        for (i = 0; i < 5; i++) pulse(1'h0, 10);
        rc(8'h36, 8'h17, 8'hff);
        wr(8'h1e, 8'h00);
        subsec = 10'h155;
        pulse(1'h0, 10);
        rc(8'h36, 8'h17, 8'hff);
        rc(8'h1e, 8'h00, 8'hff);
        rc(8'h21, 8'he9, 8'hff);
        end_test("stop after eight");
        do_reset();
        cfg(8'h82);
        for (i = 0; i < 9; i++) begin
            dt[7:0] = i[7:0];
            pulse(1'h1, 10);
        end
        wr(8'h1d, 8'h00);
        rc(8'h36, 8'h11, 8'hff);
        rc(8'h41, 8'h08, 8'hff);
        rc(8'h49, 8'h01, 8'hff);
        wr(8'h2e, 8'h01);
        subsec = 10'h2c4;
        rc(8'h2f, 8'h00, 8'hff);
        rc(8'h36, 8'h12, 8'hff);
        chk_stamp(8'hff, 8'hff);
        end_test("overwrite and trigger");
        for (i = 1; i < 4; i++) begin
            do_reset();
            subsec = 10'h3ff;
            cfg({1'h1, i[1:0], 5'h00});
            pulse(1'h1, 3);
            rc(8'h36, 8'h08, 8'hff);
            pulse(1'h1, hold[i]);
            rc(8'h36, 8'h01, 8'hff);
            chk_stamp(m20[i], m21[i]);
            rc(8'h40, 8'hff, mh[i]);
        end
        end_test("debounce");
        wr(8'h2b, 8'h84);
        drv_en = 1'h0;
        cyc(10);
        rc(8'h36, 8'h02, 8'hff);
        wr(8'h2b, 8'h90);
        cyc(10);
        wr(8'h2b, 8'h84);
        cyc(10);
        rc(8'h36, 8'h03, 8'hff);
        end_test("pull network");
        test_done();
    end
endmodule : event_pin_time_stamp_tb

`default_nettype wire
